// >>> wrc_core.sv
// watchdog timer control, reset flag, timed-access unlock and APB slave
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
module wrc_core #(
  parameter int unsigned TO_SEL0 = 131072,    // 2^17 clocks
  parameter int unsigned TO_SEL1 = 1048576,   // 2^20 clocks
  parameter int unsigned TO_SEL2 = 8388608,   // 2^23 clocks
  parameter int unsigned TO_SEL3 = 67108864   // 2^26 clocks
) (
  input  wire logic        clk_sys,        // system clock, 100 MHz
  input  wire logic        reset,          // power-on reset, sync, high
  input  wire logic        powerFailRst,   // power-fail/down reset, same clock
  input  wire logic        resetPin,       // external reset pin, async, high
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb enable
  input  wire logic        pwrite,         // apb direction
  input  wire logic [11:0] paddr,          // apb byte address
  input  wire logic [31:0] pwdata,         // apb write data
  output logic             pready,         // apb ready
  output logic [31:0]      prdata,         // apb read data
  output logic             pslverr,        // apb error, unmapped address
  output logic             wdtIrq,         // watchdog interrupt to core
  output logic             wdtResetOut,    // watchdog system reset pulse
  output logic             irqOut          // summary interrupt, level
);

  // control and status state
  wrc_pkg::wrc_ctrl_t              ctrl_q;      // control register, view of the field flops
  logic                            run_q;       // run bit
  logic [1:0]                      sel_q;       // timeout select
  logic                            toFlag_q;    // timeout flag
  logic                            rstFlag_q;   // watchdog reset flag
  logic                            rstEn_q;     // reset enable
  logic                            restart_q;   // self-clearing restart bit
  logic [7:0]                      extIe_q;     // extended irq enable
  logic [wrc_pkg::IS_W-1:0]        iStat_q;     // sticky event status
  logic [wrc_pkg::IS_W-1:0]        iMask_q;     // event mask
  logic [wrc_pkg::CNT_W-1:0]       count_q;     // watchdog counter
  wrc_pkg::wrc_ta_t                ta_q;        // unlock state
  logic [3:0]                      taCnt_q;     // unlock window counter
  logic [2:0]                      pinSync_q;   // pin synchroniser
  logic                            pinLvl_q;    // filtered pin level
  logic                            ready_q;     // apb answer flop
  logic [31:0]                     rdata_q;     // apb read data flop
  logic                            err_q;       // apb error flop

  // decoded bus events
  logic                            acc;         // access phase, answering
  logic                            wr;          // write takes effect
  logic [9:0]                      idx;         // register index
  logic                            hitKey;      // key register hit
  logic                            hitCtrl;     // control register hit
  logic                            mapped;      // any register hit
  logic                            ctrlWr;      // ordinary control write
  logic                            protWr;      // unlocked control write
  logic [7:0]                      wd;          // write data byte
  logic [wrc_pkg::CNT_W-1:0]       limit;       // selected timeout
  logic                            expire;      // timeout point reached
  logic                            rstPoint;    // reset point reached
  logic                            wdtFire;     // watchdog reset happens
  logic                            anyRst;      // any reset source

  // bus decode; answer comes in the second access cycle
  assign acc     = psel & penable & ready_q;
  assign wr      = acc & pwrite;
  assign idx     = paddr[11:2];
  assign hitKey  = (idx == wrc_pkg::IDX_KEY);
  assign hitCtrl = (idx == wrc_pkg::IDX_CTRL);
  assign mapped  = hitKey | hitCtrl | (idx == wrc_pkg::IDX_EXTIE)
                 | (idx == wrc_pkg::IDX_ISTAT) | (idx == wrc_pkg::IDX_IMASK);
  assign wd      = pwdata[7:0];
  assign ctrlWr  = wr & hitCtrl;
  assign protWr  = ctrlWr & (ta_q == wrc_pkg::TA_OPEN);
  assign anyRst  = reset | powerFailRst | pinLvl_q | wdtFire;

  // control register assembled from one flop per field; reserved bit reads zero
  assign ctrl_q  = {run_q, 1'b0, sel_q, toFlag_q, rstFlag_q, rstEn_q, restart_q};

  // timeout select decode
  always_comb begin
    case (ctrl_q.sel)
      2'b00:   limit = wrc_pkg::CNT_W'(TO_SEL0);
      2'b01:   limit = wrc_pkg::CNT_W'(TO_SEL1);
      2'b10:   limit = wrc_pkg::CNT_W'(TO_SEL2);
      default: limit = wrc_pkg::CNT_W'(TO_SEL3);
    endcase
  end

  // timeout point and reset point, reset 512 clocks after timeout
  assign expire   = ctrl_q.run & (count_q == limit - 27'h0000001);
  assign rstPoint = ctrl_q.run
                  & (count_q == limit + wrc_pkg::RESET_DELAY - 27'h0000001);
  assign wdtFire  = rstPoint & ctrl_q.rstEn;

  // pin reset synchroniser; change taken when stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pinSync_q <= 3'h0;
      pinLvl_q  <= 1'b0;
    end else begin
      pinSync_q <= {pinSync_q[1:0], resetPin};
      if (pinSync_q[1] == pinSync_q[2]) begin
        pinLvl_q <= pinSync_q[2];
      end
    end
  end

  // watchdog counter
  always_ff @(posedge clk_sys) begin
    if (anyRst) begin
      count_q <= '0;
    end else if (ctrl_q.restart) begin
      count_q <= '0;
    end else if (!ctrl_q.run) begin
      count_q <= count_q;
    end else if (rstPoint) begin
      count_q <= '0;  // no reset enabled: start a new period
    end else begin
      count_q <= count_q + 27'h0000001;
    end
  end

  // timed-access unlock sequencer
  always_ff @(posedge clk_sys) begin
    if (anyRst) begin
      ta_q    <= wrc_pkg::TA_IDLE;
      taCnt_q <= 4'h0;
    end else begin
      case (ta_q)
        wrc_pkg::TA_IDLE: begin
          if (wr & hitKey & (wd == wrc_pkg::KEY_FIRST)) begin
            ta_q <= wrc_pkg::TA_HALF;
          end
        end
        wrc_pkg::TA_HALF: begin
          if (wr) begin
            // any write other than the second key aborts
            if (hitKey & (wd == wrc_pkg::KEY_SECOND)) begin
              ta_q    <= wrc_pkg::TA_OPEN;
              taCnt_q <= wrc_pkg::TA_WINDOW;
            end else begin
              ta_q <= wrc_pkg::TA_IDLE;
            end
          end
        end
        wrc_pkg::TA_OPEN: begin
          // closes after one control write, any other write, or timeout
          if (wr | (taCnt_q == 4'h1)) begin
            ta_q <= wrc_pkg::TA_IDLE;
          end
          taCnt_q <= taCnt_q - 4'h1;
        end
        default: begin
          ta_q <= wrc_pkg::TA_IDLE;
        end
      endcase
    end
  end

  // run and timeout select: protected, cleared by every reset
  always_ff @(posedge clk_sys) begin
    if (anyRst) begin
      run_q <= 1'b0;
      sel_q <= 2'b00;
    end else if (protWr) begin
      run_q <= wd[wrc_pkg::B_RUN];
      sel_q <= wd[wrc_pkg::B_SELHI:wrc_pkg::B_SELLO];
    end
  end

  // timeout flag: hardware sets on expiry, software clears; set wins
  always_ff @(posedge clk_sys) begin
    if (reset | powerFailRst | pinLvl_q | wdtFire) begin
      toFlag_q <= 1'b0;
    end else if (expire) begin
      toFlag_q <= 1'b1;
    end else if (protWr) begin
      toFlag_q <= wd[wrc_pkg::B_TOFLAG];
    end
  end

  // reset flag: kept across pin reset, cleared by power resets
  always_ff @(posedge clk_sys) begin
    if (reset | powerFailRst) begin
      rstFlag_q <= 1'b0;
    end else if (wdtFire) begin
      rstFlag_q <= 1'b1;
    end else if (ctrlWr) begin
      rstFlag_q <= wd[wrc_pkg::B_RSTFLAG];
    end
  end

  // reset enable: cleared by power-on, pin and watchdog resets
  always_ff @(posedge clk_sys) begin
    if (reset | powerFailRst | pinLvl_q | wdtFire) begin
      rstEn_q <= 1'b0;
    end else if (protWr) begin
      rstEn_q <= wd[wrc_pkg::B_RSTEN];
    end
  end

  // restart: one-cycle bit that clears itself
  always_ff @(posedge clk_sys) begin
    if (anyRst) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= protWr & wd[wrc_pkg::B_RESTART];
    end
  end

  // extended irq enable, interrupt mask
  always_ff @(posedge clk_sys) begin
    if (reset | powerFailRst | pinLvl_q) begin
      extIe_q <= 8'h00;
      iMask_q <= '0;
    end else if (wr) begin
      if (idx == wrc_pkg::IDX_EXTIE) begin
        extIe_q <= wd;
      end
      if (idx == wrc_pkg::IDX_IMASK) begin
        iMask_q <= wd[wrc_pkg::IS_W-1:0];
      end
    end
  end

  // sticky event status, write one to clear; a new event wins
  always_ff @(posedge clk_sys) begin
    if (reset | powerFailRst) begin
      iStat_q <= '0;
    end else begin
      for (int i = 0; i < wrc_pkg::IS_W; i++) begin
        if ((i == wrc_pkg::IS_TIMEOUT) ? expire : wdtFire) begin
          iStat_q[i] <= 1'b1;
        end else if (wr & (idx == wrc_pkg::IDX_ISTAT) & wd[i]) begin
          iStat_q[i] <= 1'b0;
        end
      end
    end
  end

  // interrupt and reset outputs, all from flops
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wdtIrq      <= 1'b0;
      wdtResetOut <= 1'b0;
      irqOut      <= 1'b0;
    end else begin
      wdtIrq      <= ctrl_q.toFlag & extIe_q[wrc_pkg::B_WDIE];
      wdtResetOut <= wdtFire;
      irqOut      <= |(iStat_q & iMask_q);
    end
  end

  // apb answer: ready in the second access cycle, data and error with it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ready_q <= 1'b0;
      rdata_q <= 32'h00000000;
      err_q   <= 1'b0;
    end else begin
      ready_q <= psel & penable & ~ready_q;
      err_q   <= psel & penable & ~ready_q & ~mapped;
      rdata_q <= 32'h00000000;
      if (psel & penable & ~ready_q & ~pwrite) begin
        case (idx)
          wrc_pkg::IDX_CTRL:  rdata_q[7:0] <= ctrl_q;
          wrc_pkg::IDX_EXTIE: rdata_q[7:0] <= extIe_q;
          wrc_pkg::IDX_ISTAT: rdata_q[wrc_pkg::IS_W-1:0] <= iStat_q;
          wrc_pkg::IDX_IMASK: rdata_q[wrc_pkg::IS_W-1:0] <= iMask_q;
          default:            rdata_q <= 32'h00000000;  // key reads zero
        endcase
      end
    end
  end

  assign pready  = ready_q;
  assign prdata  = rdata_q;
  assign pslverr = err_q;

endmodule // wrc_core

// >>> wrc_pkg.sv
// package: register map, field layout and timing constants of the watchdog control block
// Operation
// - watchdog reset sets reset flag bit 2
// - flag cleared only by software or resets
// - power-fail/on/down reset clears reset flag
// - reset pin leaves reset flag unchanged
// - enable low: no reset, flag untouched
// - enable bit 1 cleared by POR/pin/watchdog
// - restart bit 0 returns counter to zero
// - restart bit clears itself in hardware
// - expiry raises interrupt when irq enabled
// - reset follows timeout point by 512 clocks
// - control register always readable
// - protected bits need timed-access unlock
// - other bits write freely
// - run bit 7 stops or runs counter
// - timeout flag set on expiry
package wrc_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0]  IDX_KEY     = 10'h0C7;
  localparam logic [9:0]  IDX_CTRL    = 10'h0D8;
  localparam logic [9:0]  IDX_EXTIE   = 10'h0E8;
  localparam logic [9:0]  IDX_ISTAT   = 10'h0F0;
  localparam logic [9:0]  IDX_IMASK   = 10'h0F1;
  localparam int          ADDR_W      = 12;
  // control register bit positions
  localparam int          B_RUN       = 7;
  localparam int          B_SELHI     = 5;
  localparam int          B_SELLO     = 4;
  localparam int          B_TOFLAG    = 3;
  localparam int          B_RSTFLAG   = 2;
  localparam int          B_RSTEN     = 1;
  localparam int          B_RESTART   = 0;
  localparam int          B_WDIE      = 4;   // irq enable bit in extended enable
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  // interrupt status bits
  localparam int          IS_TIMEOUT  = 0;
  localparam int          IS_WDRESET  = 1;
  localparam int          IS_W        = 2;
  // timed-access keys and window
  localparam logic [7:0]  KEY_FIRST   = 8'hAA;
  localparam logic [7:0]  KEY_SECOND  = 8'h55;
  localparam logic [3:0]  TA_WINDOW   = 4'h8;  // cycles the unlock stays open
  // counter timing, in clocks
  localparam int          CNT_W       = 27;
  localparam logic [26:0] RESET_DELAY = 27'h0000200;  // 512 clocks
  // control register fields
  typedef struct packed {
    logic       run;
    logic       rsvd;
    logic [1:0] sel;
    logic       toFlag;
    logic       rstFlag;
    logic       rstEn;
    logic       restart;
  } wrc_ctrl_t;
  // unlock sequencer
  typedef enum logic [1:0] {TA_IDLE, TA_HALF, TA_OPEN} wrc_ta_t;
endpackage

// >>> wrc_core_props.sv
// checker: bus timing and watchdog output relations seen at the block's ports
`timescale 1ns/10ps
module wrc_core_props (
  input wire logic        clk_sys,       // system clock
  input wire logic        reset,         // power-on reset
  input wire logic        powerFailRst,  // power-fail reset
  input wire logic        resetPin,      // reset pin
  input wire logic        psel,          // apb select
  input wire logic        penable,       // apb enable
  input wire logic        pwrite,        // apb direction
  input wire logic [11:0] paddr,         // apb address
  input wire logic [31:0] pwdata,        // apb write data
  input wire logic        pready,        // apb ready
  input wire logic [31:0] prdata,        // apb read data
  input wire logic        pslverr,       // apb error
  input wire logic        wdtIrq,        // watchdog interrupt
  input wire logic        wdtResetOut,   // watchdog reset pulse
  input wire logic        irqOut         // summary interrupt
);
  logic [9:0] idx;     // register index of the transfer
  logic       mapped;  // index names a register
  assign idx = paddr[11:2];
  assign mapped = idx inside {wrc_pkg::IDX_KEY, wrc_pkg::IDX_CTRL, wrc_pkg::IDX_EXTIE,
                              wrc_pkg::IDX_ISTAT, wrc_pkg::IDX_IMASK};
  // all checks on the system clock, quiet during reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_ready_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("ready did not follow one wait cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  chk_ready_req: assert property (pready |-> psel && penable)
    else $error("ready without an access");
  chk_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("error flag does not match address decode");
  chk_rd_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  chk_key_read: assert property (pready && !pwrite && idx == wrc_pkg::IDX_KEY |-> prdata == 32'h0)
    else $error("key register read not zero");
  chk_reset_once: assert property (wdtResetOut |=> !wdtResetOut [*8])
    else $error("watchdog reset pulse repeated");
  chk_reset_late: assert property ($rose(wdtIrq) |-> !wdtResetOut [*8])
    else $error("watchdog reset too close to timeout");
  chk_reset_idle: assert property ($fell(reset) |-> !wdtResetOut && !wdtIrq && !irqOut && !pready)
    else $error("outputs active after reset");
endmodule // wrc_core_props
bind wrc_core wrc_core_props wrc_core_props_inst (.clk_sys(clk_sys), .reset(reset),
  .powerFailRst(powerFailRst), .resetPin(resetPin), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .wdtIrq(wdtIrq), .wdtResetOut(wdtResetOut), .irqOut(irqOut));

// >>> watchdog_reset_control_tb.sv
// testbench: register access, unlock, timeout and reset-source sequences
`timescale 1ns/10ps
module watchdog_reset_control_tb;
  logic        clk_sys, reset, powerFailRst, resetPin;  // clock and resets
  logic        psel, penable, pwrite, pready, pslverr;  // apb controls
  logic [11:0] paddr;                                   // apb address
  logic [31:0] pwdata, prdata, rd;                      // apb data, last read
  logic        err, wdtIrq, wdtResetOut, irqOut;        // last error, outputs
  int          failures = 0;                            // mismatch count
  int          compares = 0;                            // comparison count
  int          rstSeen = 0;                             // watchdog reset pulses
  int          n, m;                                    // cycle counts
  int          t[4];                                    // cycles to timeout per select
  localparam int LIM [4] = '{64, 128, 256, 1024};       // shortened periods
  wrc_core #(.TO_SEL0(64), .TO_SEL1(128), .TO_SEL2(256), .TO_SEL3(1024)) wrc_core_inst (
    .clk_sys(clk_sys), .reset(reset), .powerFailRst(powerFailRst), .resetPin(resetPin),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .wdtIrq(wdtIrq),
    .wdtResetOut(wdtResetOut), .irqOut(irqOut));
  // free-running 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // count watchdog reset pulses
  always @(posedge clk_sys) if (wdtResetOut === 1'b1) rstSeen <= rstSeen + 1;
  task automatic report_and_stop();
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic [9:0] idx, input logic isWr, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= isWr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d);
  endtask
  task automatic rdchk(input string nm, input logic [9:0] idx, input logic [31:0] exp);
    apb(idx, 1'b0, 8'h00);
    check(nm, rd, exp);
  endtask
  // key pair that opens the protected-write window
  task automatic unlock();
    wr(wrc_pkg::IDX_KEY, wrc_pkg::KEY_FIRST);
    wr(wrc_pkg::IDX_KEY, wrc_pkg::KEY_SECOND);
  endtask
  task automatic waitirq(output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while (wdtIrq !== 1'b1 && c < 5000);
  endtask
  // cuts a hung run short
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    report_and_stop();
  end
  // main sequence
  initial begin
    {reset, powerFailRst, resetPin, psel, penable, pwrite} = 6'b100000;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    rdchk("ctrl at reset", wrc_pkg::IDX_CTRL, 32'h00);
    apb(10'h001, 1'b0, 8'h00);
    check("unmapped error", {31'h0, err}, 32'h1);
    wr(wrc_pkg::IDX_CTRL, 8'h87);
    rdchk("locked write", wrc_pkg::IDX_CTRL, 32'h04);
    wr(wrc_pkg::IDX_CTRL, 8'h00);
    rdchk("flag cleared", wrc_pkg::IDX_CTRL, 32'h00);
    unlock();
    wr(wrc_pkg::IDX_IMASK, 8'h01);
    wr(wrc_pkg::IDX_CTRL, 8'h80);
    rdchk("window closed", wrc_pkg::IDX_CTRL, 32'h00);
    wr(wrc_pkg::IDX_EXTIE, 8'h10);
    repeat (6) begin
      unlock();
      wr(wrc_pkg::IDX_CTRL, 8'h81);
    end
    check("restart defers", {31'h0, wdtIrq}, 32'h0);
    rdchk("restart clears", wrc_pkg::IDX_CTRL, 32'h80);
    waitirq(n);
    check("irq raised", {31'h0, wdtIrq}, 32'h1);
    rdchk("timeout flag", wrc_pkg::IDX_CTRL, 32'h88);
    rdchk("status timeout", wrc_pkg::IDX_ISTAT, 32'h01);
    check("irq out", {31'h0, irqOut}, 32'h1);
    wr(wrc_pkg::IDX_ISTAT, 8'h01);
    repeat (2) @(posedge clk_sys);
    check("irq out cleared", {31'h0, irqOut}, 32'h0);
    repeat (700) @(posedge clk_sys);
    check("no reset disabled", 32'(rstSeen), 32'h0);
    rdchk("flag untouched", wrc_pkg::IDX_CTRL, 32'h88);
    unlock();
    wr(wrc_pkg::IDX_CTRL, 8'h83);
    repeat (3) @(posedge clk_sys);
    waitirq(n);
    m = 0;
    do begin
      @(posedge clk_sys);
      m++;
    end while (wdtResetOut !== 1'b1 && m < 2000);
    check("reset delay", 32'(m), 32'd511);
    // the pulse counter updates at the edge that ended the wait
    @(posedge clk_sys);
    check("one reset", 32'(rstSeen), 32'h1);
    rdchk("after wd reset", wrc_pkg::IDX_CTRL, 32'h04);
    rdchk("status wd reset", wrc_pkg::IDX_ISTAT, 32'h03);
    resetPin <= 1'b1;
    repeat (2) @(posedge clk_sys);
    resetPin <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rdchk("pin keeps flag", wrc_pkg::IDX_CTRL, 32'h04);
    powerFailRst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    powerFailRst <= 1'b0;
    rdchk("power fail clears", wrc_pkg::IDX_CTRL, 32'h00);
    for (int s = 0; s < 4; s++) begin
      powerFailRst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      powerFailRst <= 1'b0;
      wr(wrc_pkg::IDX_EXTIE, 8'h10);
      unlock();
      wr(wrc_pkg::IDX_CTRL, 8'h81 | 8'(s << 4));
      waitirq(t[s]);
    end
    for (int s = 1; s < 4; s++) check("select period", 32'(t[s] - t[0]), 32'(LIM[s] - LIM[0]));
    report_and_stop();
  end
endmodule // watchdog_reset_control_tb
